// file: logic/pcs_pkg.sv
// constants shared by the clock select controller and the clock generator end
// What this block does
// R1: center frequency is L times 2^E times 71.4kHz
// R2: software picks N, E, L near VCO
// R3: software writes E into exponent bits
// R4: software writes N; low byte before power
// R5: software writes L into range register
// R6: multiplier zero behaves as one
// R7: L zero disables PLL, forces crystal
// R8: switch waits three edges each, output held; when leaving the vco, only three crystal edges are waited on
// R9: selected clock divided by two, even duty
// R10: select bit picks crystal or VCO clock
// R11: VCO select refused while power off
// R12: power off refused while VCO selected
// R13: power and select never change together
// R14: system enable gates oscillator and PLL
// R15: run-in-stop bit keeps oscillator running
// R16: programming registers locked while powered
// R17: software never programs E as three
// R18: reset clears select, crystal drives output
// R19: no output pulse shorter than source half-period
// R20: VCO used only when selected, powered, L nonzero
package pcs_pkg;
    // device register addresses
    localparam logic [7:0] CTRL_ADDR = 8'h36;
    localparam logic [7:0] MULT_HI_ADDR = 8'h38;
    localparam logic [7:0] MULT_LO_ADDR = 8'h39;
    localparam logic [7:0] RANGE_ADDR = 8'h3A;
    // control register fields
    localparam int CTRL_POWER_BIT = 5;
    localparam int CTRL_SELECT_BIT = 4;
    localparam int EXP_LSB = 0;
    localparam int EXP_W = 2;
    localparam int MULT_HI_W = 4;
    localparam int MULT_LO_W = 8;
    localparam int MULT_W = MULT_HI_W + MULT_LO_W;
    localparam int RANGE_W = 8;
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h20;
    localparam logic [7:0] MULT_HI_RST = 8'h00;
    localparam logic [7:0] MULT_LO_RST = 8'h40;
    localparam logic [7:0] RANGE_RST = 8'h40;
    // nominal VCO step, 71.4 kHz, in Hz
    localparam logic [31:0] NOM_STEP_HZ = 32'h0001_16E8;
    // source edges waited on each side when switching to the vco; when leaving it, only the crystal side is waited on
    localparam int SWITCH_EDGES = 3;
    // avalon register byte offsets
    localparam logic [7:0] AV_DEV_WRITE = 8'h00;
    localparam logic [7:0] AV_DEV_ADDR = 8'h04;
    localparam logic [7:0] AV_DEV_READ = 8'h08;
    localparam logic [7:0] AV_CONFIG = 8'h0C;
    localparam logic [7:0] AV_STATUS = 8'h10;
    localparam int DW_ADDR_LSB = 8;
    localparam int CFG_RUN_IN_STOP_BIT = 0;
    localparam int STAT_VCO_BIT = 0;
    localparam int STAT_SWITCHING_BIT = 1;
    localparam int READ_WAIT_CYCLES = 2;
endpackage

// file: logic/pcs_if.sv
// register port and control lines between the controller and the clock generator end
`timescale 1ns/100ps
interface pcs_if;
    logic reg_wr;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic osc_enable_from_sysint;
    logic stop_mode;
    logic osc_run_in_stop;
    logic on_vco;
    logic switching;

    modport gen (
        input reg_wr,
        input reg_addr,
        input reg_wdata,
        output reg_rdata,
        input osc_enable_from_sysint,
        input stop_mode,
        input osc_run_in_stop,
        output on_vco,
        output switching
    );

    modport ctrl (
        output reg_wr,
        output reg_addr,
        output reg_wdata,
        input reg_rdata,
        output osc_enable_from_sysint,
        output stop_mode,
        output osc_run_in_stop,
        input on_vco,
        input switching
    );
endinterface

// file: logic/pcs_clk_switch.sv
// glitch-free crystal / vco switch with divide-by-two output
`timescale 1ns/100ps
module pcs_clk_switch #(
    parameter int EDGES = pcs_pkg::SWITCH_EDGES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // source clocks, sampled as pins
    input wire logic crystal_clock,
    input wire logic vco_clock,
    // selection
    input wire logic want_vco,
    // result
    output logic clk_out,
    output logic on_vco,
    output logic switching
);
    localparam int CW = $clog2(EDGES + 1);
    localparam logic [CW-1:0] CNT_DONE = CW'(EDGES);

    typedef enum logic {PCS_RUN, PCS_HOLD} pcs_sw_state_t;

    typedef struct packed {
        logic [2:0] xs;
        logic [2:0] vs;
        logic xl;
        logic vl;
        logic cur_vco;
        logic out;
        pcs_sw_state_t st;
        logic [CW-1:0] xcnt;
        logic [CW-1:0] vcnt;
    } pcs_sw_t;

    pcs_sw_t s;
    pcs_sw_t next_s;

    always_comb begin
        logic x_rise;
        logic v_rise;
        x_rise = 1'b0;
        v_rise = 1'b0;
        next_s = s;
        next_s.xs = {s.xs[1:0], crystal_clock};
        next_s.vs = {s.vs[1:0], vco_clock};
        // a level counts once the last two stages agree
        if (s.xs[2] == s.xs[1]) begin
            next_s.xl = s.xs[2];
        end
        if (s.vs[2] == s.vs[1]) begin
            next_s.vl = s.vs[2];
        end
        x_rise = next_s.xl & ~s.xl;
        v_rise = next_s.vl & ~s.vl;
        unique case (s.st)
            PCS_RUN: begin
                if (want_vco != s.cur_vco) begin
                    next_s.st = PCS_HOLD;
                    next_s.xcnt = '0;
                    next_s.vcnt = '0;
                end else if (s.cur_vco ? v_rise : x_rise) begin
                    // output only moves on a source edge, so no pulse is shorter than a source period
                    next_s.out = ~s.out; // R9 R19
                end
            end
            PCS_HOLD: begin
                // output held while the crystal side settles, and also the vco side when moving to the vco
                if (x_rise && s.xcnt != CNT_DONE) begin
                    next_s.xcnt = s.xcnt + 1'b1; // R8
                end
                if (v_rise && s.vcnt != CNT_DONE) begin
                    next_s.vcnt = s.vcnt + 1'b1; // R8
                end
                // a vco being dropped may already have stopped, so only the crystal side is awaited then
                if (s.xcnt == CNT_DONE && (s.vcnt == CNT_DONE || !want_vco)) begin
                    next_s.cur_vco = want_vco; // R10
                    next_s.st = PCS_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '{xs: 3'h0, vs: 3'h0, xl: 1'b0, vl: 1'b0, cur_vco: 1'b0, out: 1'b0,
                   st: PCS_RUN, xcnt: '0, vcnt: '0};
        end else begin
            s <= next_s;
        end
    end

    assign clk_out = s.out;
    assign on_vco = s.cur_vco;
    assign switching = (s.st == PCS_HOLD);
endmodule

// file: logic/pcs_gen.sv
// clock generator end: programming registers, interlocks, oscillator enables and base clock
`timescale 1ns/100ps
module pcs_gen (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // controller side
    pcs_if.gen BUS,
    // source clocks from the oscillator and the vco
    input wire logic CRYSTAL_CLOCK,
    input wire logic VCO_CLOCK,
    // base clock towards the system
    output logic BASE_CLOCK_OUT,
    // analog enables
    output logic OSC_ENABLE,
    output logic PLL_ENABLE,
    // loop settings for the analog part
    output logic [pcs_pkg::MULT_W-1:0] MULT_EFFECTIVE,
    output logic [pcs_pkg::EXP_W-1:0] VCO_RANGE_EXPONENT,
    output logic [31:0] CENTER_FREQ_HZ
);
    typedef struct packed {
        logic pll_power_on;
        logic base_source_select;
        logic [pcs_pkg::EXP_W-1:0] vco_range_exponent;
        logic [pcs_pkg::MULT_W-1:0] mult;
        logic [pcs_pkg::RANGE_W-1:0] range;
        logic [7:0] rdata;
        logic [pcs_pkg::MULT_W-1:0] mult_eff;
        logic [31:0] center;
        logic osc_en;
        logic pll_en;
    } pcs_gen_t;

    pcs_gen_t s;
    pcs_gen_t next_s;
    logic want_vco;
    logic clk_out;
    logic on_vco;
    logic switching;

    // register image as software sees it
    function automatic logic [7:0] read_reg(input pcs_gen_t r, input logic [7:0] addr);
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            pcs_pkg::CTRL_ADDR: begin
                v[pcs_pkg::CTRL_POWER_BIT] = r.pll_power_on;
                v[pcs_pkg::CTRL_SELECT_BIT] = r.base_source_select;
                v[pcs_pkg::EXP_LSB +: pcs_pkg::EXP_W] = r.vco_range_exponent;
            end
            pcs_pkg::MULT_HI_ADDR: begin
                v[pcs_pkg::MULT_HI_W-1:0] = r.mult[pcs_pkg::MULT_W-1:pcs_pkg::MULT_LO_W];
            end
            pcs_pkg::MULT_LO_ADDR: begin
                v = r.mult[pcs_pkg::MULT_LO_W-1:0];
            end
            pcs_pkg::RANGE_ADDR: begin
                v = r.range;
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    always_comb begin
        logic want_on;
        logic want_sel;
        logic range_ok;
        want_on = BUS.reg_wdata[pcs_pkg::CTRL_POWER_BIT];
        want_sel = BUS.reg_wdata[pcs_pkg::CTRL_SELECT_BIT];
        range_ok = (s.range != '0);
        next_s = s;
        if (BUS.reg_wr) begin
            case (BUS.reg_addr)
                pcs_pkg::CTRL_ADDR: begin
                    // a write touching both power and select is dropped for both
                    if (!(want_on != s.pll_power_on && want_sel != s.base_source_select)) begin // R13
                        if (!(s.base_source_select && !want_on)) begin // R12
                            next_s.pll_power_on = want_on;
                        end
                        // vco accepted only with power already on and a usable range
                        next_s.base_source_select = want_sel & s.pll_power_on & range_ok; // R11 R7 R10
                    end
                    if (!s.pll_power_on) begin // R16
                        next_s.vco_range_exponent = BUS.reg_wdata[pcs_pkg::EXP_LSB +: pcs_pkg::EXP_W];
                    end
                end
                pcs_pkg::MULT_HI_ADDR: begin
                    if (!s.pll_power_on) begin // R16
                        next_s.mult[pcs_pkg::MULT_W-1:pcs_pkg::MULT_LO_W] =
                            BUS.reg_wdata[pcs_pkg::MULT_HI_W-1:0];
                    end
                end
                pcs_pkg::MULT_LO_ADDR: begin
                    if (!s.pll_power_on) begin // R16
                        next_s.mult[pcs_pkg::MULT_LO_W-1:0] = BUS.reg_wdata;
                    end
                end
                pcs_pkg::RANGE_ADDR: begin
                    if (!s.pll_power_on) begin // R16
                        next_s.range = BUS.reg_wdata;
                    end
                end
                default: begin
                    next_s.range = s.range;
                end
            endcase
        end
        // a zero range can never leave the vco selected
        if (next_s.range == '0) begin
            next_s.base_source_select = 1'b0; // R7
        end
        next_s.rdata = read_reg(next_s, BUS.reg_addr);
        // zero multiplier acts as one
        next_s.mult_eff = (s.mult == '0) ? pcs_pkg::MULT_W'(1) : s.mult; // R6
        // range code scaled by the power of two, times the nominal step
        next_s.center = (32'(s.range) << s.vco_range_exponent) * pcs_pkg::NOM_STEP_HZ; // R1
        // stop mode keeps the oscillator when the config bit asks for it; a high system enable keeps it regardless
        next_s.osc_en = BUS.osc_enable_from_sysint | (BUS.stop_mode & BUS.osc_run_in_stop); // R14 R15
        // pll needs the system enable, its power bit and a nonzero range
        next_s.pll_en = BUS.osc_enable_from_sysint & s.pll_power_on & range_ok; // R14 R7
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            s.pll_power_on <= pcs_pkg::CTRL_RST[pcs_pkg::CTRL_POWER_BIT];
            s.base_source_select <= pcs_pkg::CTRL_RST[pcs_pkg::CTRL_SELECT_BIT]; // R18
            s.vco_range_exponent <= pcs_pkg::CTRL_RST[pcs_pkg::EXP_LSB +: pcs_pkg::EXP_W];
            s.mult <= {pcs_pkg::MULT_HI_RST[pcs_pkg::MULT_HI_W-1:0], pcs_pkg::MULT_LO_RST};
            s.range <= pcs_pkg::RANGE_RST;
            s.rdata <= 8'h00;
            s.mult_eff <= {pcs_pkg::MULT_HI_RST[pcs_pkg::MULT_HI_W-1:0], pcs_pkg::MULT_LO_RST};
            s.center <= 32'h0000_0000;
            s.osc_en <= 1'b0;
            s.pll_en <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // effective source: vco only when every condition holds
    assign want_vco = s.base_source_select & s.pll_power_on & (s.range != '0); // R20

    pcs_clk_switch #(
        .EDGES(pcs_pkg::SWITCH_EDGES)
    ) u_switch (
        .clk(CLK),
        .rstn(RSTN),
        .crystal_clock(CRYSTAL_CLOCK),
        .vco_clock(VCO_CLOCK),
        .want_vco(want_vco),
        .clk_out(clk_out),
        .on_vco(on_vco),
        .switching(switching)
    );

    assign BASE_CLOCK_OUT = clk_out;
    assign OSC_ENABLE = s.osc_en;
    assign PLL_ENABLE = s.pll_en;
    assign MULT_EFFECTIVE = s.mult_eff;
    assign VCO_RANGE_EXPONENT = s.vco_range_exponent;
    assign CENTER_FREQ_HZ = s.center;
    assign BUS.reg_rdata = s.rdata;
    assign BUS.on_vco = on_vco;
    assign BUS.switching = switching;
endmodule

// file: logic/pcs_ctrl.sv
// controller end: avalon-mm slave that programs the clock generator and forwards system enables
`timescale 1ns/100ps
module pcs_ctrl (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // avalon-mm slave
    input wire logic [7:0] AV_ADDRESS,
    input wire logic AV_READ,
    input wire logic AV_WRITE,
    input wire logic [31:0] AV_WRITEDATA,
    input wire logic [3:0] AV_BYTEENABLE,
    output logic [31:0] AV_READDATA,
    output logic AV_WAITREQUEST,
    // system integration
    input wire logic SYSINT_OSC_ENABLE,
    input wire logic STOP_MODE,
    // clock generator side
    pcs_if.ctrl BUS
);
    typedef enum logic [1:0] {PCS_IDLE, PCS_READ, PCS_ACK} pcs_ctrl_state_t;

    typedef struct packed {
        pcs_ctrl_state_t st;
        logic [1:0] wait_cnt;
        logic [31:0] readdata;
        logic [15:0] dev_word;
        logic [7:0] rd_addr;
        logic dev_wr;
        logic run_in_stop;
    } pcs_ctrl_t;

    pcs_ctrl_t s;
    pcs_ctrl_t next_s;

    // byte-lane merge for partial writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                v[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return v;
    endfunction

    always_comb begin
        logic [31:0] cfg;
        logic [31:0] m;
        cfg = 32'h0000_0000;
        cfg[pcs_pkg::CFG_RUN_IN_STOP_BIT] = s.run_in_stop;
        m = 32'h0000_0000;
        next_s = s;
        next_s.dev_wr = 1'b0;
        unique case (s.st)
            PCS_IDLE: begin
                if (AV_READ || AV_WRITE) begin
                    next_s.readdata = 32'h0000_0000;
                    next_s.st = PCS_ACK;
                    case (AV_ADDRESS)
                        pcs_pkg::AV_DEV_WRITE: next_s.readdata = {16'h0000, s.dev_word};
                        pcs_pkg::AV_DEV_ADDR: next_s.readdata = {24'h000000, s.rd_addr};
                        pcs_pkg::AV_CONFIG: next_s.readdata = cfg;
                        pcs_pkg::AV_STATUS: begin
                            next_s.readdata[pcs_pkg::STAT_VCO_BIT] = BUS.on_vco;
                            next_s.readdata[pcs_pkg::STAT_SWITCHING_BIT] = BUS.switching;
                        end
                        pcs_pkg::AV_DEV_READ: begin
                            // device read data lags its address, so give it time to settle
                            if (AV_READ) begin
                                next_s.st = PCS_READ;
                                next_s.wait_cnt = 2'(pcs_pkg::READ_WAIT_CYCLES - 1);
                            end
                        end
                        default: next_s.readdata = 32'h0000_0000;
                    endcase
                end
            end
            PCS_READ: begin
                if (s.wait_cnt == 2'h0) begin
                    next_s.readdata = {24'h000000, BUS.reg_rdata};
                    next_s.st = PCS_ACK;
                end else begin
                    next_s.wait_cnt = s.wait_cnt - 2'h1;
                end
            end
            PCS_ACK: begin
                // a write lands only at the edge that sees waitrequest low
                if (AV_WRITE) begin
                    case (AV_ADDRESS)
                        pcs_pkg::AV_DEV_WRITE: begin
                            m = merge({16'h0000, s.dev_word}, AV_WRITEDATA, AV_BYTEENABLE);
                            next_s.dev_word = m[15:0];
                            next_s.dev_wr = 1'b1; // R3 R4 R5
                        end
                        pcs_pkg::AV_DEV_ADDR: begin
                            m = merge({24'h000000, s.rd_addr}, AV_WRITEDATA, AV_BYTEENABLE);
                            next_s.rd_addr = m[7:0];
                        end
                        pcs_pkg::AV_CONFIG: begin
                            m = merge(cfg, AV_WRITEDATA, AV_BYTEENABLE);
                            next_s.run_in_stop = m[pcs_pkg::CFG_RUN_IN_STOP_BIT]; // R15
                        end
                        default: next_s.rd_addr = s.rd_addr;
                    endcase
                end
                next_s.st = PCS_IDLE;
            end
            default: next_s.st = PCS_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            s <= '{st: PCS_IDLE, wait_cnt: 2'h0, readdata: 32'h0000_0000, dev_word: 16'h0000,
                   rd_addr: 8'h00, dev_wr: 1'b0, run_in_stop: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign AV_READDATA = s.readdata;
    assign AV_WAITREQUEST = (s.st != PCS_ACK);
    assign BUS.reg_wr = s.dev_wr;
    assign BUS.reg_addr = s.dev_wr ? s.dev_word[pcs_pkg::DW_ADDR_LSB +: 8] : s.rd_addr;
    assign BUS.reg_wdata = s.dev_word[7:0];
    assign BUS.osc_enable_from_sysint = SYSINT_OSC_ENABLE; // R14
    assign BUS.stop_mode = STOP_MODE;
    assign BUS.osc_run_in_stop = s.run_in_stop;
endmodule

// file: verif/pcs_props.sv
// assertion checker on the link between the controller end and the clock generator end
`timescale 1ns/100ps
module pcs_props (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // link signals
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic on_vco,
    input wire logic switching
);
    logic m_pwr;
    logic m_sel;
    logic [1:0] m_exp;
    logic [7:0] m_l;
    logic [7:0] sw_cnt;
    logic m_want;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    // shadow of the device control state, rebuilt from the write strobes only
    assign m_want = m_sel & m_pwr & (m_l != 8'h00);
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            m_pwr <= 1'b1;
            m_sel <= 1'b0;
            m_exp <= 2'h0;
            m_l <= pcs_pkg::RANGE_RST;
        end else if (reg_wr && reg_addr == pcs_pkg::CTRL_ADDR) begin
            if (!m_pwr)
                m_exp <= reg_wdata[1:0];
            if (!(reg_wdata[5] != m_pwr && reg_wdata[4] != m_sel)) begin
                m_pwr <= reg_wdata[5] | m_sel;
                m_sel <= reg_wdata[4] & m_pwr & (m_l != 8'h00);
            end
        end else if (reg_wr && reg_addr == pcs_pkg::RANGE_ADDR && !m_pwr) begin
            m_l <= reg_wdata;
        end
    end

    // wrapping would hide a stuck switch, so the bound is checked well below wrap
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN)
            sw_cnt <= 8'h00;
        else if (switching)
            sw_cnt <= sw_cnt + 8'h01;
        else
            sw_cnt <= 8'h00;
    end

    sequence s_want_moved;
        $changed(m_want);
    endsequence
    sequence s_settled;
        on_vco == m_want && !switching;
    endsequence
    sequence s_steady(logic [7:0] a);
        $past(reg_addr) == a && $past(reg_addr, 2) == a && !$past(reg_wr) && !$past(reg_wr, 2);
    endsequence

    property p_wr_pulse;
        reg_wr |=> !reg_wr;
    endproperty
    property p_settle;
        s_want_moved |-> ##[1:250] s_settled;
    endproperty
    property p_held;
        $changed(on_vco) |-> $past(switching) || $past(switching, 2);
    endproperty
    property p_sw_len;
        sw_cnt < 8'hC8;
    endproperty
    property p_rose_want;
        $rose(on_vco) |-> m_want;
    endproperty
    property p_unpowered;
        !m_pwr && !on_vco |=> !on_vco;
    endproperty
    property p_ctrl_read;
        s_steady(pcs_pkg::CTRL_ADDR) |-> {reg_rdata[5:4], reg_rdata[1:0]} == {m_pwr, m_sel, m_exp};
    endproperty
    property p_range_read;
        s_steady(pcs_pkg::RANGE_ADDR) |-> reg_rdata == m_l;
    endproperty

    a_wr_pulse: assert property (p_wr_pulse) else $error("device write strobe longer than one cycle");
    a_settle: assert property (p_settle) else $error("source switch did not settle in time");
    a_held: assert property (p_held) else $error("source changed outside a held switch");
    a_sw_len: assert property (p_sw_len) else $error("switch hold lasts too long");
    a_rose_want: assert property (p_rose_want) else $error("vco taken without valid selection");
    a_unpowered: assert property (p_unpowered) else $error("vco taken with pll off");
    a_ctrl_read: assert property (p_ctrl_read) else $error("control readback differs");
    a_range_read: assert property (p_range_read) else $error("range readback differs");
endmodule

// file: verif/pcs_tb_top.sv
// testbench joining controller and clock generator ends through the link interface
`timescale 1ns/100ps
module pcs_tb_top;
    localparam logic [7:0] CT = pcs_pkg::CTRL_ADDR;
    localparam logic [7:0] RG = pcs_pkg::RANGE_ADDR;
    logic clk, rstn, xclk, vclk, av_rd, av_wr, av_wait, sysint, stop, base, osc_en, pll_en, base_q, sw_q;
    logic [7:0] av_addr;
    logic [31:0] av_wd, av_q, cfreq;
    logic [11:0] mult;
    logic [1:0] expo;
    int err_total = 0;
    int check_count = 0;

    pcs_if pcs_if_i();
    pcs_ctrl pcs_ctrl_i (.CLK(clk), .RSTN(rstn), .AV_ADDRESS(av_addr), .AV_READ(av_rd), .AV_WRITE(av_wr),
        .AV_WRITEDATA(av_wd), .AV_BYTEENABLE(4'hF), .AV_READDATA(av_q), .AV_WAITREQUEST(av_wait),
        .SYSINT_OSC_ENABLE(sysint), .STOP_MODE(stop), .BUS(pcs_if_i.ctrl));
    pcs_gen pcs_gen_i (.CLK(clk), .RSTN(rstn), .BUS(pcs_if_i.gen), .CRYSTAL_CLOCK(xclk), .VCO_CLOCK(vclk),
        .BASE_CLOCK_OUT(base), .OSC_ENABLE(osc_en), .PLL_ENABLE(pll_en), .MULT_EFFECTIVE(mult),
        .VCO_RANGE_EXPONENT(expo), .CENTER_FREQ_HZ(cfreq));
    pcs_props pcs_props_i (.CLK(clk), .RSTN(rstn), .reg_wr(pcs_if_i.reg_wr), .reg_addr(pcs_if_i.reg_addr),
        .reg_wdata(pcs_if_i.reg_wdata), .reg_rdata(pcs_if_i.reg_rdata), .on_vco(pcs_if_i.on_vco),
        .switching(pcs_if_i.switching));

    // source clocks kept slow so every level spans many sampling cycles
    always #4 clk = ~clk;
    always #56 xclk = ~xclk;
    always #32 vclk = ~vclk;

    task automatic results();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    always @(posedge clk) begin
        if (sw_q && pcs_if_i.switching === 1'b1 && base !== base_q) begin
            err_total++;
            $display("Error base_clock_out expected %b seen %b", base_q, base);
        end
        base_q <= base;
        sw_q <= pcs_if_i.switching;
    end

    task automatic av(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        av_addr <= a;
        av_wd <= d;
        av_wr <= w;
        av_rd <= !w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (av_wait !== 1'b0 && n < 40);
        q = av_q;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
        if (n >= 40) begin
            err_total++;
            $display("Error waitrequest expected 0 seen 1");
            results();
        end
    endtask

    task automatic dw(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        av(1'b1, pcs_pkg::AV_DEV_WRITE, {16'h0, a, d}, q);
        repeat (3) @(posedge clk);
    endtask

    task automatic dr(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input string nm);
        logic [31:0] q;
        av(1'b1, pcs_pkg::AV_DEV_ADDR, {24'h0, a}, q);
        av(1'b0, pcs_pkg::AV_DEV_READ, 32'h0, q);
        chk(nm, {24'h0, e & m}, q & {24'h0, m});
    endtask

    task automatic wait_vco(input logic e);
        int n;
        n = 0;
        while (pcs_if_i.on_vco !== e && n < 400) begin
            @(posedge clk);
            n++;
        end
        if (n >= 400) begin
            err_total++;
            $display("Error on_vco expected %b seen %b", e, pcs_if_i.on_vco);
            results();
        end
    endtask

    // base clock toggles once per source rising edge: 20 source periods give 20 toggles
    task automatic tog(input int cyc, input string nm);
        int n;
        logic p;
        n = 0;
        p = base;
        repeat (cyc) begin
            @(posedge clk);
            if (base !== p)
                n++;
            p = base;
        end
        check_count++;
        if (n < 19 || n > 21) begin
            err_total++;
            $display("Error %s expected 20 seen %0d", nm, n);
        end
    endtask

    task automatic t_reset();
        dr(CT, pcs_pkg::CTRL_RST, 8'h33, "ctrl");
        dr(pcs_pkg::MULT_LO_ADDR, 8'h40, 8'hFF, "mult_lo");
        chk("center", 32'h40 * pcs_pkg::NOM_STEP_HZ, cfreq);
        tog(280, "crystal_rate");
    endtask

    task automatic t_program();
        dw(RG, 8'h10);
        dr(RG, 8'h40, 8'hFF, "range_locked");
        dw(CT, 8'h00);
        dw(pcs_pkg::MULT_HI_ADDR, 8'h00);
        dw(pcs_pkg::MULT_LO_ADDR, 8'h00);
        chk("mult_eff", 32'h1, {20'h0, mult});
        dw(CT, 8'h02);
        dw(RG, 8'h46);
        chk("exponent", 32'h2, {30'h0, expo});
        chk("center", 32'h46 * 32'h4 * pcs_pkg::NOM_STEP_HZ, cfreq);
    endtask

    task automatic t_interlock();
        logic [31:0] q;
        dw(CT, 8'h32);
        dr(CT, 8'h02, 8'h33, "both_change");
        dw(CT, 8'h12);
        dr(CT, 8'h02, 8'h33, "sel_unpowered");
        dw(CT, 8'h22);
        chk("pll_enable", 32'h1, {31'h0, pll_en});
        dw(CT, 8'h32);
        wait_vco(1'b1);
        av(1'b0, pcs_pkg::AV_STATUS, 32'h0, q);
        chk("status", 32'h1, q & 32'h3);
        tog(160, "vco_rate");
        dw(CT, 8'h02);
        dr(CT, 8'h32, 8'h33, "off_and_desel");
        dw(CT, 8'h12);
        dr(CT, 8'h32, 8'h33, "off_while_vco");
        dw(CT, 8'h22);
        wait_vco(1'b0);
        tog(280, "crystal_back");
    endtask

    task automatic t_osc();
        logic [31:0] q;
        @(posedge clk);
        sysint <= 1'b0;
        stop <= 1'b1;
        repeat (4) @(posedge clk);
        chk("osc_off", 32'h0, {31'h0, osc_en});
        chk("pll_off", 32'h0, {31'h0, pll_en});
        av(1'b1, pcs_pkg::AV_CONFIG, 32'h1, q);
        repeat (4) @(posedge clk);
        chk("osc_in_stop", 32'h1, {31'h0, osc_en});
        av(1'b1, pcs_pkg::AV_CONFIG, 32'h0, q);
        sysint <= 1'b1;
        stop <= 1'b0;
        repeat (4) @(posedge clk);
        chk("osc_on", 32'h1, {31'h0, osc_en});
        av(1'b0, 8'h20, 32'h0, q);
        chk("unmapped", 32'h0, q);
    endtask

    task automatic t_lzero();
        dw(CT, 8'h00);
        dw(RG, 8'h00);
        dw(CT, 8'h20);
        dw(CT, 8'h30);
        dr(CT, 8'h20, 8'h33, "l_zero_sel");
        chk("pll_l_zero", 32'h0, {31'h0, pll_en});
        repeat (100) @(posedge clk);
        chk("on_vco", 32'h0, {31'h0, pcs_if_i.on_vco});
    endtask

    initial begin
        clk = 1'b0;
        xclk = 1'b0;
        vclk = 1'b0;
        rstn = 1'b0;
        av_rd = 1'b0;
        av_wr = 1'b0;
        av_addr = 8'h00;
        av_wd = 32'h0;
        sysint = 1'b1;
        stop = 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_program();
        t_interlock();
        t_osc();
        t_lzero();
        results();
    end
endmodule
